//--- design/mae_pkg.sv
// shared constants and types for the instruction execution block
package mae_pkg;
  localparam int unsigned MEM_DEPTH = 256;  // data memory words
  localparam int unsigned PC_W      = 13;   // program counter width

  // register byte offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_W      = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0c;
  localparam logic [7:0] REG_MADDR  = 8'h10;
  localparam logic [7:0] REG_MDATA  = 8'h14;
  localparam logic [7:0] REG_CYCLES = 8'h18;
  localparam logic [7:0] REG_NONE   = 8'hfc;  // marks an unmapped address

  // instruction word fields
  localparam int unsigned F_ADDR_LSB = 0;
  localparam int unsigned F_LIT_LSB  = 8;
  localparam int unsigned F_BIT_LSB  = 16;
  localparam int unsigned F_DEST_BIT = 19;
  localparam int unsigned F_OP_LSB   = 24;

  // status bits
  localparam int unsigned STS_C_BIT  = 0;
  localparam int unsigned STS_DC_BIT = 1;
  localparam int unsigned STS_Z_BIT  = 2;

  // reset values and arithmetic constants
  localparam logic [PC_W-1:0] RESET_PC  = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP   = 13'h0001;
  localparam logic [PC_W-1:0] JUMP_WRAP = 13'h0100;
  localparam logic [31:0]     CYC_STEP  = 32'h0000_0001;
  localparam logic [7:0]      BYTE_ZERO = 8'h00;
  localparam logic [4:0]      NIB_MAX   = 5'h0f;

  typedef enum logic [3:0] {
    OP_ADD_LIT   = 4'h0,
    OP_JUMP_W    = 4'h1,
    OP_ADD_REG   = 4'h2,
    OP_ADD_REG_C = 4'h3,
    OP_AND_LIT   = 4'h4,
    OP_AND_REG   = 4'h5,
    OP_CLR_BIT   = 4'h6,
    OP_SET_BIT   = 4'h7,
    OP_TEST_SKIP = 4'h8,
    OP_NOP       = 4'hf
  } mae_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10,
    ST_EXTRA = 2'b11
  } mae_state_t;
endpackage

//--- design/mae_ram.sv
// data memory with a registered read port
`timescale 1ns/1ps
module mae_ram
  import mae_pkg::*;
(
  input  wire logic       clk,    // core clock
  input  wire logic       we,     // write strobe
  input  wire logic [7:0] waddr,  // write address
  input  wire logic [7:0] wdata,  // write data
  input  wire logic [7:0] raddr,  // read address
  output logic      [7:0] rdata   // read data, one edge after raddr
);
  logic [7:0] mem [MEM_DEPTH];  // storage, no reset: contents undefined

  // read before write on a shared address
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

//--- design/mae_core.sv
// instruction execution core with an ahb-lite register slave
`timescale 1ns/1ps
module mae_core
  import mae_pkg::*;
(
  input  wire logic        hclk,       // core and bus clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write not read
  input  wire logic [2:0]  hsize,      // word only
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready in
  output logic      [31:0] hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp       // always okay
);
  // all state of the core
  typedef struct packed {
    mae_state_t      st;        // execution state
    logic [PC_W-1:0] pc;        // program counter
    logic [7:0]      w;         // accumulator
    logic            c;         // carry flag
    logic            dc;        // nibble carry flag
    logic            z;         // zero flag
    logic [31:0]     instr;     // instruction being run
    logic [7:0]      maddr;     // memory window address
    logic [31:0]     cycles;    // executed instruction cycles
    logic            dph;       // bus data phase pending
    logic [7:0]      baddr;     // latched register offset
    logic            bwrite;    // latched direction
    logic            rdy;       // hreadyout
    logic [31:0]     rdata;     // hrdata
    logic            was_idle;  // engine idle last cycle
  } mae_regs_t;

  mae_regs_t s_q;  // registered state
  mae_regs_t s_d;  // next state

  // decoded instruction fields
  mae_op_t    op;        // operation
  logic [7:0] f_addr;    // operand address
  logic [7:0] f_lit;     // literal value
  logic [2:0] f_bit;     // bit index
  logic       f_dest;    // 1 writes memory
  logic [7:0] bit_mask;  // one-hot bit select

  // datapath
  logic [7:0] opnd;       // memory operand
  logic [7:0] add_b;      // second addend
  logic       cin;        // carry in
  logic [8:0] sum9;       // sum with carry out
  logic [4:0] nib5;       // low nibble sum
  logic [7:0] and_res;    // and result
  logic [PC_W-1:0] jump_tgt;  // relative jump target
  logic       accept;     // address phase taken
  logic [31:0] rd_mux;    // register read value

  // memory ports
  logic       mem_we;     // memory write
  logic [7:0] mem_waddr;  // memory write address
  logic [7:0] mem_wdata;  // memory write data
  logic [7:0] mem_raddr;  // memory read address

  assign op       = mae_op_t'(s_q.instr[F_OP_LSB +: 4]);
  assign f_addr   = s_q.instr[F_ADDR_LSB +: 8];
  assign f_lit    = s_q.instr[F_LIT_LSB +: 8];
  assign f_bit    = s_q.instr[F_BIT_LSB +: 3];
  assign f_dest   = s_q.instr[F_DEST_BIT];
  assign bit_mask = 8'(8'h01 << f_bit);

  // adder shared by all three add operations
  assign cin   = (op == OP_ADD_REG_C) ? s_q.c : 1'b0;
  assign add_b = (op == OP_ADD_LIT) ? f_lit : opnd;
  assign sum9  = {1'b0, s_q.w} + {1'b0, add_b} + {8'h00, cin};
  assign nib5  = {1'b0, s_q.w[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
  assign and_res = s_q.w & ((op == OP_AND_LIT) ? f_lit : opnd);

  // high accumulator values count as negative offsets
  assign jump_tgt = s_q.pc + PC_STEP + {5'h00, s_q.w}
                    - (s_q.w[7] ? JUMP_WRAP : RESET_PC);

  // engine owns the read port while fetching the operand
  assign mem_raddr = (s_q.st == ST_FETCH) ? f_addr : s_q.maddr;

  assign accept = hsel && htrans[1] && hready;

  assign hrdata    = s_q.rdata;
  assign hreadyout = s_q.rdy;
  assign hresp     = 1'b0;

  mae_ram u_ram (
    .clk   (hclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (opnd)
  );

  // register read mux
  always_comb begin
    case (s_q.baddr)
      REG_INSTR:  rd_mux = s_q.instr;
      REG_W:      rd_mux = {24'h0, s_q.w};
      REG_STATUS: rd_mux = {29'h0, s_q.z, s_q.dc, s_q.c};
      REG_PC:     rd_mux = {19'h0, s_q.pc};
      REG_MADDR:  rd_mux = {24'h0, s_q.maddr};
      REG_MDATA:  rd_mux = {24'h0, opnd};
      REG_CYCLES: rd_mux = s_q.cycles;
      default:    rd_mux = 32'h0;  // unmapped reads zero
    endcase
  end

  // next state: engine then bus slave
  always_comb begin
    s_d        = s_q;
    mem_we     = 1'b0;
    mem_waddr  = f_addr;
    mem_wdata  = sum9[7:0];
    s_d.was_idle = (s_q.st == ST_IDLE);
    case (s_q.st)
      ST_IDLE: begin
        s_d.st = ST_IDLE;  // waits for an instruction write
      end
      ST_FETCH: begin
        s_d.st = ST_EXEC;  // operand read in flight
      end
      ST_EXEC: begin
        s_d.cycles = s_q.cycles + CYC_STEP;
        s_d.pc     = s_q.pc + PC_STEP;
        s_d.st     = ST_IDLE;
        case (op)
          OP_ADD_LIT: begin
            s_d.w  = sum9[7:0];
            s_d.c  = sum9[8];
            s_d.dc = nib5[4];
            s_d.z  = (sum9[7:0] == BYTE_ZERO);
          end
          OP_JUMP_W: begin
            s_d.pc = jump_tgt;
            s_d.st = ST_EXTRA;
          end
          OP_ADD_REG, OP_ADD_REG_C: begin
            if (f_dest) begin
              mem_we = 1'b1;
            end else begin
              s_d.w = sum9[7:0];
            end
            s_d.c  = sum9[8];
            s_d.dc = nib5[4];
            s_d.z  = (sum9[7:0] == BYTE_ZERO);
          end
          OP_AND_LIT: begin
            s_d.w = and_res;
            s_d.z = (and_res == BYTE_ZERO);
          end
          OP_AND_REG: begin
            mem_wdata = and_res;
            if (f_dest) begin
              mem_we = 1'b1;
            end else begin
              s_d.w = and_res;
            end
            s_d.z = (and_res == BYTE_ZERO);
          end
          OP_CLR_BIT: begin
            mem_we    = 1'b1;
            mem_wdata = opnd & ~bit_mask;
          end
          OP_SET_BIT: begin
            mem_we    = 1'b1;
            mem_wdata = opnd | bit_mask;
          end
          OP_TEST_SKIP: begin
            // discarded fetch becomes a spare cycle
            if (!opnd[f_bit]) begin
              s_d.pc = s_q.pc + PC_STEP + PC_STEP;
              s_d.st = ST_EXTRA;
            end
          end
          default: begin
            s_d.st = ST_IDLE;  // unknown codes act as no-op
          end
        endcase
      end
      ST_EXTRA: begin
        s_d.cycles = s_q.cycles + CYC_STEP;  // second cycle, no effect
        s_d.st     = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // bus: address phase latch, then one or more wait states
    if (s_q.rdy) begin
      s_d.dph = accept;
      if (accept) begin
        s_d.rdy    = 1'b0;
        s_d.bwrite = hwrite;
        s_d.baddr  = (haddr[31:8] == 24'h0) ? haddr[7:0] : REG_NONE;
      end
    end else if (s_q.dph && (s_q.st == ST_IDLE) && s_q.was_idle) begin
      // only touch state once the engine is quiet and read data settled
      s_d.rdy = 1'b1;
      if (s_q.bwrite) begin
        case (s_q.baddr)
          REG_INSTR: begin
            s_d.instr = hwdata;
            s_d.st    = ST_FETCH;
          end
          REG_W: begin
            s_d.w = hwdata[7:0];
          end
          REG_STATUS: begin
            s_d.c  = hwdata[STS_C_BIT];
            s_d.dc = hwdata[STS_DC_BIT];
            s_d.z  = hwdata[STS_Z_BIT];
          end
          REG_PC: begin
            s_d.pc = hwdata[PC_W-1:0];
          end
          REG_MADDR: begin
            s_d.maddr = hwdata[7:0];
          end
          REG_MDATA: begin
            mem_we    = 1'b1;
            mem_waddr = s_q.maddr;
            mem_wdata = hwdata[7:0];
          end
          REG_CYCLES: begin
            s_d.cycles = hwdata;
          end
          default: begin
            s_d.rdy = 1'b1;  // unmapped writes ignored
          end
        endcase
      end else begin
        s_d.rdata = rd_mux;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: ST_IDLE, pc: RESET_PC, rdy: 1'b1, was_idle: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic exec_q;  // engine in its execute cycle
  assign exec_q = (s_q.st == ST_EXEC);

  add_lit_a: assert property (
    exec_q && (op == OP_ADD_LIT) |=> (s_q.st == ST_IDLE)
      && (s_q.w == 8'($past(s_q.w) + $past(f_lit))))
    else $error("literal add wrong");

  jump_a: assert property (
    exec_q && (op == OP_JUMP_W) |=> (s_q.st == ST_EXTRA)
      && (s_q.pc == PC_W'($past(s_q.pc) + PC_STEP + {{5{$past(s_q.w[7])}}, $past(s_q.w)}))
      && $stable({s_q.c, s_q.dc, s_q.z}) ##1 (s_q.st == ST_IDLE))
    else $error("relative jump wrong");

  add_reg_a: assert property (
    exec_q && (op == OP_ADD_REG) && !f_dest
      |=> (s_q.w == 8'($past(s_q.w) + $past(opnd))) && (s_q.z == (s_q.w == BYTE_ZERO)))
    else $error("register add wrong");

  // memory target must get the full result, carry in included for the carry form
  dest_mem_a: assert property (
    exec_q && f_dest && ((op == OP_ADD_REG) || (op == OP_ADD_REG_C) || (op == OP_AND_REG))
      |-> mem_we && (mem_waddr == f_addr)
      && (mem_wdata == ((op == OP_AND_REG) ? (s_q.w & opnd)
                        : 8'(s_q.w + opnd + {7'h00, (op == OP_ADD_REG_C) && s_q.c})))
      ##1 $stable(s_q.w))
    else $error("memory target not written");

  add_carry_a: assert property (
    exec_q && (op == OP_ADD_REG_C) && !f_dest
      |=> ({s_q.c, s_q.w} == 9'({1'b0, $past(s_q.w)} + {1'b0, $past(opnd)}
                                + {8'h00, $past(s_q.c)})))
    else $error("add with carry wrong");

  and_lit_a: assert property (
    exec_q && (op == OP_AND_LIT) |=> (s_q.w == ($past(s_q.w) & $past(f_lit))))
    else $error("literal and wrong");

  and_reg_a: assert property (
    exec_q && (op == OP_AND_REG) && !f_dest
      |=> (s_q.w == ($past(s_q.w) & $past(opnd))) && (s_q.z == (s_q.w == BYTE_ZERO)))
    else $error("register and wrong");

  clr_bit_a: assert property (
    exec_q && (op == OP_CLR_BIT) |-> mem_we && !mem_wdata[f_bit]
      && ((mem_wdata | bit_mask) == (opnd | bit_mask))
      ##1 $stable({s_q.c, s_q.dc, s_q.z}) && (s_q.st == ST_IDLE))
    else $error("bit clear wrong");

  set_bit_a: assert property (
    exec_q && (op == OP_SET_BIT) |-> mem_we && mem_wdata[f_bit]
      && ((mem_wdata & ~bit_mask) == (opnd & ~bit_mask))
      ##1 $stable({s_q.c, s_q.dc, s_q.z}) && (s_q.st == ST_IDLE))
    else $error("bit set wrong");

  skip_taken_a: assert property (
    exec_q && (op == OP_TEST_SKIP) && !opnd[f_bit]
      |=> (s_q.st == ST_EXTRA) && (s_q.pc == PC_W'($past(s_q.pc) + PC_STEP + PC_STEP))
      ##1 (s_q.st == ST_IDLE))
    else $error("skip not taken");

  skip_none_a: assert property (
    exec_q && (op == OP_TEST_SKIP) && opnd[f_bit] |=> (s_q.st == ST_IDLE))
    else $error("skip taken wrongly");

  nibble_a: assert property (
    exec_q && (op == OP_ADD_LIT) |=> (s_q.dc == ((5'($past(s_q.w[3:0]))
      + 5'($past(f_lit[3:0]))) > NIB_MAX)) && (s_q.z == (s_q.w == BYTE_ZERO)))
    else $error("nibble carry wrong");

  add_done_c: cover property (exec_q && (op == OP_ADD_REG_C) ##1 s_q.c);
  jump_c:     cover property (exec_q && (op == OP_JUMP_W) && s_q.w[7]);
  skip_c:     cover property (exec_q && (op == OP_TEST_SKIP) ##1 (s_q.st == ST_EXTRA));
  bus_rd_c:   cover property (s_q.dph && s_q.rdy && !s_q.bwrite);
endmodule

//--- tb/mae_core_tb.sv
// self-checking bench for the instruction execution core over its ahb-lite slave
`timescale 1ns/1ps
module mae_core_tb
  import mae_pkg::*;
;
  logic        hclk;       // 10 mhz bus clock
  logic        hresetn;    // async reset, active low
  logic        hsel;       // slave select
  logic [31:0] haddr;      // byte address
  logic [1:0]  htrans;     // transfer type
  logic        hwrite;     // write not read
  logic [2:0]  hsize;      // always a word
  logic [31:0] hwdata;     // write data
  logic [31:0] hrdata;     // read data
  logic        hreadyout;  // slave ready, also the bus ready
  logic        hresp;      // response
  int          fail_count; // mismatches seen
  int          n_checks;   // comparisons made
  int          seed;       // fixed random seed

  mae_core uut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // free-running clock, half period 50 ns
  always #50 hclk = ~hclk;

  // verdict and end of run, the only exit
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one compare, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // wait for ready at a rising edge, bounded so a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    // ready seen on the last allowed edge still counts as an answer
    if (hreadyout !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask

  // single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr_reg(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, {24'h0, off}, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, {24'h0, off}, 32'h0, rd);
    chk(rd, exp);
  endtask

  // expected state after one instruction, worked out from the operation list
  function automatic void expect_op(input logic [3:0] op, input logic [7:0] w, m, k,
    input logic [2:0] st, bsel, input logic dst, input logic [12:0] pc,
    output logic [7:0] ew, em, output logic [2:0] es, output logic [12:0] ep,
    output logic [1:0] ec);
    logic [8:0] s;
    logic [7:0] r;
    logic       h;
    ew = w;
    em = m;
    es = st;
    ep = pc + 13'h1;
    ec = 2'h1;
    r  = 8'h0;
    case (op)
      4'h0, 4'h2, 4'h3: begin
        r  = (op == 4'h0) ? k : m;
        h  = (op == 4'h3) & st[0];
        s  = {1'b0, w} + {1'b0, r} + {8'h0, h};
        es = {s[7:0] == 8'h0, ({1'b0, w[3:0]} + {1'b0, r[3:0]} + {4'h0, h}) > 5'h0f, s[8]};
        r  = s[7:0];
      end
      4'h4: begin
        r     = w & k;
        es[2] = (r == 8'h0);
      end
      4'h5: begin
        r     = w & m;
        es[2] = (r == 8'h0);
      end
      4'h1: begin
        ep = pc + 13'h1 + {{5{w[7]}}, w};
        ec = 2'h2;
      end
      4'h6: em[bsel] = 1'b0;
      4'h7: em[bsel] = 1'b1;
      4'h8: if (!m[bsel]) begin
        ep = pc + 13'h2;
        ec = 2'h2;
      end
      default: ;
    endcase
    // literal forms always land in the accumulator
    if (op == 4'h0 || op == 4'h4) begin
      ew = r;
    end else if (op == 4'h2 || op == 4'h3 || op == 4'h5) begin
      if (dst) begin
        em = r;
      end else begin
        ew = r;
      end
    end
  endfunction

  // main sequence
  initial begin
    logic [7:0]  w, m, k, f, ew, em;
    logic [2:0]  st, b, es;
    logic        d;
    logic [12:0] pc, ep;
    logic [1:0]  ec;
    logic [3:0]  op;
    logic [31:0] rd;
    hclk       = 1'b0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    fail_count = 0;
    n_checks   = 0;
    seed       = 32'hcdaea558;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset state of the architectural registers
    rd_chk(REG_W, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_PC, 32'h0);
    // unmapped space reads zero and ignores writes
    bus(1'b1, 32'h0000_0100, 32'hffff_ffff, rd);
    bus(1'b0, 32'h0000_0100, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 300; i++) begin
      w  = 8'($random(seed));
      m  = 8'($random(seed));
      k  = 8'($random(seed));
      f  = 8'($random(seed));
      st = 3'($random(seed));
      b  = 3'($random(seed));
      d  = 1'($random(seed));
      pc = 13'($random(seed));
      op = 4'(($random(seed) & 32'h7fff_ffff) % 10);
      if (op == 4'h9) op = 4'hf;
      // hand-picked corners: jump by positive, negative and -2 offsets
      if (i < 3) begin
        op = 4'h1;
        pc = 13'h0212;
        w  = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'hfe;
      end
      // nibble carry with no full carry
      if (i == 3) begin
        op = 4'h0;
        w  = 8'h08;
        k  = 8'h08;
      end
      // add with carry in and a zero result
      if (i == 4) begin
        op = 4'h3;
        w  = 8'hff;
        m  = 8'h00;
        st = 3'h1;
      end
      wr_reg(REG_W, {24'h0, w});
      wr_reg(REG_STATUS, {29'h0, st});
      wr_reg(REG_PC, {19'h0, pc});
      wr_reg(REG_MADDR, {24'h0, f});
      wr_reg(REG_MDATA, {24'h0, m});
      wr_reg(REG_CYCLES, 32'h0);
      wr_reg(REG_INSTR, {4'h0, op, 4'h0, d, b, k, f});
      expect_op(op, w, m, k, st, b, d, pc, ew, em, es, ep, ec);
      rd_chk(REG_W, {24'h0, ew});
      rd_chk(REG_STATUS, {29'h0, es});
      rd_chk(REG_MDATA, {24'h0, em});
      rd_chk(REG_PC, {19'h0, ep});
      rd_chk(REG_CYCLES, {30'h0, ec});
      // window address and instruction word read back as written
      rd_chk(REG_MADDR, {24'h0, f});
      rd_chk(REG_INSTR, {4'h0, op, 4'h0, d, b, k, f});
      // jump corners against fixed targets, not only the expectation function
      if (i < 3) begin
        chk({19'h0, ep}, (i == 0) ? 32'h292 : (i == 1) ? 32'h193 : 32'h211);
      end
    end
    complete_run();
  end
endmodule
